// *** test_vector_memory_host_port.sv ***
// Self-checking testbench of the vector memory host port
`timescale 1ns/1ps
module test_vector_memory_host_port;
    logic        clk_sys       = 1'b0;
    logic        reset         = 1'b1;
    logic        ext_sync      = 1'b0;
    logic        ext_sync_sel  = 1'b1;
    logic        refresh_ready = 1'b1;
    logic        cable_out     = 1'b0;
    logic        sel_n, wr_n, rd_n, ack_n, oe, cps, rv;
    logic [15:0] din, dout;
    logic [14:0] rw;
    int          err_count  = 0;
    int          num_checks = 0;

    vmhp_host_port #(.SYNC_PERIOD(50)) i_dut (
        .clk_sys(clk_sys), .reset(reset), .dev_select_n(sel_n), .write_strobe_n(wr_n),
        .read_strobe_n(rd_n), .transfer_ack_n(ack_n), .data_in(din), .data_out(dout),
        .data_oe(oe), .cable_present_sense(cps), .ext_sync(ext_sync),
        .ext_sync_sel(ext_sync_sel), .refresh_word(rw), .refresh_valid(rv),
        .refresh_ready(refresh_ready));
    vmhp_host_model i_host (
        .clk_sys(clk_sys), .dev_select_n(sel_n), .write_strobe_n(wr_n),
        .read_strobe_n(rd_n), .transfer_ack_n(ack_n), .data_in(din), .data_out(dout),
        .data_oe(oe), .cable_out(cable_out), .cable_present_sense(cps));

    initial begin
        forever #(vmhp_pkg::CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
    end

    task automatic check(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    task automatic end_sim;
        $display("Checks made: %0d, mismatches: %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Pointer load, stores across the wrap, read back
    task automatic test_write_read;
        logic [15:0] rd;
        int          lat, hold;
        i_host.xfer(1'b1, 16'h9FFF, rd, lat, hold);
        check(lat >= vmhp_pkg::ACK_DELAY_CYC + 1 && lat <= vmhp_pkg::ACK_DELAY_CYC + 2,
              "ack delay");
        check(hold >= 1 && hold <= vmhp_pkg::ACK_HOLD_CYC + 3, "ack release");
        i_host.xfer(1'b1, 16'h2AD5, rd, lat, hold);
        i_host.xfer(1'b1, 16'h5A3C, rd, lat, hold);
        i_host.xfer(1'b1, 16'h9FFF, rd, lat, hold);
        i_host.xfer(1'b0, 16'h0000, rd, lat, hold);
        check(rd === 16'h2AD5, "read at last location");
        i_host.xfer(1'b0, 16'h0000, rd, lat, hold);
        check(rd === 16'h5A3C, "read after wrap");
        check(hold <= vmhp_pkg::ACK_HOLD_CYC + 3 && oe === 1'b0, "bus released");
        $display("test_write_read done");
    endtask

    // Strobe without select must not load the pointer
    task automatic test_select;
        logic [15:0] rd;
        int          lat, hold, seen;
        i_host.xfer(1'b1, 16'h8000, rd, lat, hold);
        i_host.stray(16'h9FFF, seen);
        check(seen == 0, "answer without select");
        i_host.xfer(1'b0, 16'h0000, rd, lat, hold);
        check(rd === 16'h5A3C, "pointer moved without select");
        $display("test_select done");
    endtask

    // Jumper on external sync, then test pattern with the cable out
    task automatic test_refresh;
        int          n, k, hi;
        logic [14:0] exp_w;
        hi = 0;
        refresh_ready <= 1'b0;
        repeat (300) begin
            @(posedge clk_sys);
            if (rv === 1'b1) begin
                hi++;
            end
        end
        check(hi == 0, "internal tick used in external mode");
        cable_out <= 1'b1;
        repeat (4) @(posedge clk_sys);
        ext_sync <= 1'b1;
        repeat (5) @(posedge clk_sys);
        ext_sync <= 1'b0;
        k = 0;
        while (rv !== 1'b1 && k < 40) begin
            @(posedge clk_sys);
            k++;
        end
        check(rv === 1'b1, "no pass after external sync");
        n = 0;
        exp_w = 15'h0000;
        for (k = 0; k < 200 && n < 16; k++) begin
            @(posedge clk_sys);
            if (rv === 1'b1 && refresh_ready === 1'b1) begin
                check(rw === exp_w, "test pattern word");
                exp_w++;
                n++;
            end
            refresh_ready <= ~refresh_ready;
        end
        check(n == 16, "test pattern stalled");
        @(posedge clk_sys);
        cable_out <= 1'b0;
        refresh_ready <= 1'b1;
        k = 0;
        while (rv === 1'b1 && k < 9000) begin
            @(posedge clk_sys);
            k++;
        end
        check(rv === 1'b0, "pass did not stop after last word");
        ext_sync_sel <= 1'b0;
        refresh_ready <= 1'b0;
        k = 0;
        while (rv !== 1'b1 && k < 60) begin
            @(posedge clk_sys);
            k++;
        end
        check(rv === 1'b1, "no pass on internal sync");
        $display("test_refresh done");
    endtask

    initial begin
        #(40000 * vmhp_pkg::CLK_PERIOD_NS);
        err_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        end_sim();
    end

    initial begin
        repeat (8) @(posedge clk_sys);
        check(ack_n === 1'b1 && oe === 1'b0 && rv === 1'b0, "reset outputs");
        reset <= 1'b0;
        $display("test_reset done");
        test_write_read();
        test_select();
        test_refresh();
        end_sim();
    end
endmodule // test_vector_memory_host_port

// *** vmhp_fifo.sv ***
// Word FIFO between the host strobes and the refresh memory
`timescale 1ns/1ps
module vmhp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
        $error("FIFO depth must be a power of two");
    end

    logic [WIDTH-1:0] store_r [DEPTH];
    logic [PW:0]      wr_ptr_r;
    logic [PW:0]      rd_ptr_r;
    wire              do_push = in_valid && in_ready;
    wire              do_pop  = out_valid && out_ready;

    assign in_ready  = (wr_ptr_r ^ rd_ptr_r) != {1'b1, {PW{1'b0}}};
    assign out_valid = wr_ptr_r != rd_ptr_r;
    assign out_data  = store_r[rd_ptr_r[PW-1:0]];

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (do_push) wr_ptr_r <= wr_ptr_r + 1'b1;
            if (do_pop) rd_ptr_r <= rd_ptr_r + 1'b1;
        end
    end

    // Storage needs no reset; reads are gated by out_valid
    always_ff @(posedge clk_sys) begin
        if (do_push) store_r[wr_ptr_r[PW-1:0]] <= in_data;
    end

    chk_no_overflow: assert property (@(posedge clk_sys) disable iff (reset)
        !in_ready |-> out_valid)
        else $error("FIFO full while empty");
endmodule // vmhp_fifo

// *** vmhp_host_model.sv ***
// Host processor model driving the parallel port strobes and bus
`timescale 1ns/1ps
module vmhp_host_model (
    // Clock
    input  wire logic                        clk_sys,
    // Strobes and acknowledge
    output logic                             dev_select_n,
    output logic                             write_strobe_n,
    output logic                             read_strobe_n,
    input  wire logic                        transfer_ack_n,
    // Bus level, resolved from both drivers
    output logic [vmhp_pkg::DATA_W-1:0]      data_in,
    input  wire logic [vmhp_pkg::DATA_W-1:0] data_out,
    input  wire logic                        data_oe,
    // Cable
    input  wire logic                        cable_out,
    output logic                             cable_present_sense
);
    logic                        host_oe = 1'b0;
    logic [vmhp_pkg::DATA_W-1:0] host_d  = 16'h0000;
    logic [vmhp_pkg::DATA_W-1:0] last_d  = 16'h0000;

    initial begin
        dev_select_n   = 1'b1;
        write_strobe_n = 1'b1;
        read_strobe_n  = 1'b1;
    end

    // Released bus shows the inverse of its last value, not a stale copy
    assign data_in = data_oe ? data_out : (host_oe ? host_d : ~last_d);
    assign cable_present_sense = cable_out;

    always @(posedge clk_sys) begin
        if (data_oe || host_oe) begin
            last_d <= data_in;
        end
    end

    // Hold strobe, select and data until acknowledge is sampled low
    task automatic xfer(input logic wr, input logic [15:0] wd, output logic [15:0] rd,
                        output int lat, output int hold);
        @(posedge clk_sys);
        dev_select_n   <= 1'b0;
        write_strobe_n <= ~wr;
        read_strobe_n  <= wr;
        host_oe        <= wr;
        host_d         <= wd;
        lat = 0;
        do begin
            @(posedge clk_sys);
            lat++;
        end while (transfer_ack_n !== 1'b0 && lat < 400);
        rd = data_in;
        dev_select_n   <= 1'b1;
        write_strobe_n <= 1'b1;
        read_strobe_n  <= 1'b1;
        host_oe        <= 1'b0;
        hold = 0;
        do begin
            @(posedge clk_sys);
            hold++;
        end while (transfer_ack_n !== 1'b1 && hold < 40);
    endtask

    // Write strobe with the device not selected
    task automatic stray(input logic [15:0] wd, output int seen);
        seen = 0;
        @(posedge clk_sys);
        write_strobe_n <= 1'b0;
        host_oe        <= 1'b1;
        host_d         <= wd;
        repeat (40) begin
            @(posedge clk_sys);
            if (transfer_ack_n !== 1'b1 || data_oe !== 1'b0) begin
                seen++;
            end
        end
        write_strobe_n <= 1'b1;
        host_oe        <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask
endmodule // vmhp_host_model

// *** vmhp_host_port.sv ***
// Host parallel port and refresh memory of the vector display
`timescale 1ns/1ps
module vmhp_host_port #(
    parameter int MEM_DEPTH     = vmhp_pkg::MEM_WORDS,
    parameter int FIFO_DEPTH    = vmhp_pkg::FIFO_WORDS,
    parameter int SYNC_PERIOD   = vmhp_pkg::INT_SYNC_CYC
) (
    // Clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        reset,
    // Host strobes
    input  wire logic                        dev_select_n,
    input  wire logic                        write_strobe_n,
    input  wire logic                        read_strobe_n,
    output logic                             transfer_ack_n,
    // Host data bus, split for the two-way pins
    input  wire logic [vmhp_pkg::DATA_W-1:0] data_in,
    output logic [vmhp_pkg::DATA_W-1:0]      data_out,
    output logic                             data_oe,
    // Cable and sync
    input  wire logic                        cable_present_sense,
    input  wire logic                        ext_sync,
    input  wire logic                        ext_sync_sel,
    // Refresh stream to the vector processor
    output logic [vmhp_pkg::DATA_W-2:0]      refresh_word,
    output logic                             refresh_valid,
    input  wire logic                        refresh_ready
);
    localparam int AW = vmhp_pkg::ADDR_W;
    localparam int DW = vmhp_pkg::DATA_W;
    localparam int SW = $clog2(SYNC_PERIOD + 1);

    if (MEM_DEPTH != (1 << AW)) begin : g_bad_mem
        $error("Memory depth must match the pointer width");
    end
    if (SYNC_PERIOD < 2) begin : g_bad_sync
        $error("Sync period too short");
    end

    // Test pattern: the word address itself, zero-extended to the refresh word width
    function automatic logic [DW-2:0] vmhp_pattern(input logic [AW-1:0] a);
        vmhp_pattern = {2'b00, a};
    endfunction

    // Pointer step with wrap at the top of memory
    function automatic logic [AW-1:0] vmhp_next(input logic [AW-1:0] a);
        vmhp_next = a + 1'b1;
    endfunction

    logic [DW-1:0]         mem_r [MEM_DEPTH];
    logic [AW-1:0]         ptr_r;
    logic [AW-1:0]         ptr_nxt;
    vmhp_pkg::vmhp_state_t state_r;
    vmhp_pkg::vmhp_state_t state_nxt;
    logic [vmhp_pkg::CNT_W-1:0] cnt_r;
    logic [DW-1:0]         rd_word_r;
    logic                  rd_cycle_r;

    // Host request decode; select gates both strobes
    wire sel      = !dev_select_n;
    wire wr_req   = sel && !write_strobe_n;
    wire rd_req   = sel && !read_strobe_n;
    wire released = dev_select_n || (write_strobe_n && read_strobe_n);

    // FIFO fill and drain
    wire           fifo_in_ready;
    wire           fifo_out_valid;
    wire [DW-1:0]  fifo_out_data;
    wire           ref_fetch;
    // Memory has one port; refresh fetch stalls the drain
    wire           drain_ready = !ref_fetch;
    wire           drain       = fifo_out_valid && drain_ready;
    wire           drain_cmd   = fifo_out_data[vmhp_pkg::CMD_BIT];
    wire           push        = (state_r == vmhp_pkg::VMHP_IDLE) && wr_req && fifo_in_ready;
    // Reads wait for pending writes so the pointer is settled
    wire           rd_take     = (state_r == vmhp_pkg::VMHP_IDLE) && rd_req && !wr_req
                                 && !fifo_out_valid && !ref_fetch;

    vmhp_fifo #(
        .WIDTH (DW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (data_in),
        .out_valid (fifo_out_valid),
        .out_ready (drain_ready),
        .out_data  (fifo_out_data)
    );

    // Pointer: command loads it, data store and host read advance it
    always_comb begin
        ptr_nxt = ptr_r;
        if (drain && drain_cmd) begin
            ptr_nxt = fifo_out_data[AW-1:0];
        end else if (drain || rd_take) begin
            ptr_nxt = vmhp_next(ptr_r);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (drain && !drain_cmd) mem_r[ptr_r] <= fifo_out_data;
    end

    // Handshake sequence
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            vmhp_pkg::VMHP_IDLE: begin
                if (push || rd_take) state_nxt = vmhp_pkg::VMHP_WAIT;
            end
            vmhp_pkg::VMHP_WAIT: begin
                if (cnt_r == vmhp_pkg::CNT_W'(vmhp_pkg::ACK_DELAY_CYC - 1)) begin
                    state_nxt = vmhp_pkg::VMHP_ACK;
                end
            end
            vmhp_pkg::VMHP_ACK: begin
                if (released) state_nxt = vmhp_pkg::VMHP_HOLD;
            end
            vmhp_pkg::VMHP_HOLD: begin
                if (cnt_r == vmhp_pkg::CNT_W'(vmhp_pkg::ACK_HOLD_CYC - 1)) begin
                    state_nxt = vmhp_pkg::VMHP_IDLE;
                end
            end
            default: state_nxt = vmhp_pkg::VMHP_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_r    <= vmhp_pkg::VMHP_IDLE;
            cnt_r      <= '0;
            ptr_r      <= vmhp_pkg::PTR_RESET;
            rd_word_r  <= vmhp_pkg::WORD_RESET;
            rd_cycle_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= (state_nxt != state_r) ? '0 : cnt_r + 1'b1;
            ptr_r   <= ptr_nxt;
            if (rd_take) rd_word_r <= mem_r[ptr_r];
            if (push) rd_cycle_r <= 1'b0;
            else if (rd_take) rd_cycle_r <= 1'b1;
        end
    end

    // Ack and bus drive; hold stage keeps ack low briefly past release
    assign transfer_ack_n = !(state_r == vmhp_pkg::VMHP_ACK
                              || state_r == vmhp_pkg::VMHP_HOLD);
    assign data_oe        = rd_cycle_r && rd_req && (state_r != vmhp_pkg::VMHP_IDLE);
    assign data_out       = rd_word_r;

    // Sync source: internal divider or external edge
    logic [SW-1:0] div_r;
    logic          ext_sync_d_r;
    wire           int_tick = div_r == SW'(SYNC_PERIOD - 1);
    wire           ext_tick = ext_sync && !ext_sync_d_r;
    wire           sync_tick = ext_sync_sel ? ext_tick : int_tick;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            div_r        <= '0;
            ext_sync_d_r <= 1'b0;
        end else begin
            div_r        <= int_tick ? '0 : div_r + 1'b1;
            ext_sync_d_r <= ext_sync;
        end
    end

    // Refresh walk; a sync during a pass makes the next pass start at once
    logic [AW-1:0]  ref_addr_r;
    logic           running_r;
    logic           sync_pend_r;
    logic           ref_valid_r;
    logic [DW-2:0]  ref_word_r;
    wire            ref_last  = ref_fetch && (ref_addr_r == AW'(MEM_DEPTH - 1));
    wire            cable_out = cable_present_sense;
    // Picture data uses bits below the command bit only
    wire [DW-2:0]   ref_src   = cable_out ? vmhp_pattern(ref_addr_r)
                                          : mem_r[ref_addr_r][DW-2:0];

    assign ref_fetch = running_r && (!ref_valid_r || refresh_ready);

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ref_addr_r  <= '0;
            running_r   <= 1'b0;
            sync_pend_r <= 1'b0;
            ref_valid_r <= 1'b0;
            ref_word_r  <= '0;
        end else begin
            if (ref_fetch) begin
                ref_addr_r <= vmhp_next(ref_addr_r);
                ref_word_r <= ref_src;
            end
            if (ref_fetch) ref_valid_r <= 1'b1;
            else if (refresh_ready) ref_valid_r <= 1'b0;
            // Sync set wins over the end-of-pass clear
            if (ref_last) begin
                running_r   <= sync_pend_r || sync_tick;
                sync_pend_r <= 1'b0;
            end else if (sync_tick) begin
                if (running_r) sync_pend_r <= 1'b1;
                running_r <= 1'b1;
            end
        end
    end

    assign refresh_word  = ref_word_r;
    assign refresh_valid = ref_valid_r;

    // Cycles since the last take; saturates so a long strobe hold cannot wrap it
    logic [vmhp_pkg::CNT_W-1:0] since_take_r;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            since_take_r <= '1;
        end else if (push || rd_take) begin
            since_take_r <= '0;
        end else if (since_take_r != '1) begin
            since_take_r <= since_take_r + 1'b1;
        end
    end

    // Checks
    chk_ack_delay_min: assert property (@(posedge clk_sys) disable iff (reset)
        !transfer_ack_n |-> since_take_r >= vmhp_pkg::CNT_W'(vmhp_pkg::ACK_DELAY_CYC))
        else $error("Acknowledge too early");
    chk_ack_delay_max: assert property (@(posedge clk_sys) disable iff (reset)
        (push || rd_take) |-> ##[1:24] !transfer_ack_n)
        else $error("Acknowledge too late");
    chk_ack_holds_strobe: assert property (@(posedge clk_sys) disable iff (reset)
        (state_r == vmhp_pkg::VMHP_ACK && !released) |=> !transfer_ack_n)
        else $error("Acknowledge dropped while strobe held");
    chk_ack_release: assert property (@(posedge clk_sys) disable iff (reset)
        (state_r == vmhp_pkg::VMHP_ACK && released) |-> ##[1:3] transfer_ack_n)
        else $error("Acknowledge stuck after release");
    chk_ptr_advance: assert property (@(posedge clk_sys) disable iff (reset)
        rd_take |=> ptr_r == AW'($past(ptr_r) + 1'b1))
        else $error("Pointer did not advance after read");
    chk_ptr_load_cmd: assert property (@(posedge clk_sys) disable iff (reset)
        (drain && drain_cmd) |=> ptr_r == $past(fifo_out_data[AW-1:0]))
        else $error("Command did not load pointer");
    chk_read_data: assert property (@(posedge clk_sys) disable iff (reset)
        rd_take |=> data_out == $past(mem_r[ptr_r]))
        else $error("Read word mismatch");
    chk_ptr_wrap: assert property (@(posedge clk_sys) disable iff (reset)
        (drain && !drain_cmd && ptr_r == AW'(MEM_DEPTH - 1)) |=> ptr_r == '0)
        else $error("Pointer did not wrap");
    chk_test_pattern: assert property (@(posedge clk_sys) disable iff (reset)
        (ref_fetch && cable_present_sense) |=> refresh_word == $past(vmhp_pattern(ref_addr_r)))
        else $error("Test pattern not shown with cable out");
    chk_sync_source: assert property (@(posedge clk_sys) disable iff (reset)
        (!running_r && ext_sync_sel && !ext_tick && !ref_fetch) |=> !running_r)
        else $error("Refresh started without selected sync");
endmodule // vmhp_host_port

// *** vmhp_pkg.sv ***
// Shared constants and types of the vector memory host port
package vmhp_pkg;
    localparam int DATA_W          = 16;
    localparam int ADDR_W          = 13;
    localparam int MEM_WORDS       = 8192;
    localparam int FIFO_WORDS      = 32;
    localparam int CMD_BIT         = 15;
    localparam int CLK_HZ          = 50_000_000;
    localparam int CLK_PERIOD_NS   = 20;
    localparam int ACK_DELAY_NS    = 455;
    localparam int ACK_DELAY_CYC   = (ACK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACK_HOLD_NS     = 40;
    localparam int ACK_HOLD_CYC    = (ACK_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INT_SYNC_HZ     = 60;
    localparam int INT_SYNC_CYC    = CLK_HZ / INT_SYNC_HZ;
    localparam int CNT_W           = 6;
    localparam logic [ADDR_W-1:0] PTR_RESET = 13'h0000;
    localparam logic [DATA_W-1:0] WORD_RESET = 16'h0000;
    typedef enum logic [1:0] {
        VMHP_IDLE,
        VMHP_WAIT,
        VMHP_ACK,
        VMHP_HOLD
    } vmhp_state_t;
endpackage
